// File: logic/sdsr_pkg.sv
package sdsr_pkg;

  // ****************************************
  // Register map (printed offsets are word indices)
  // ****************************************
  localparam logic [7:0]  OUT3_DELAY_IDX      = 8'h18;
  localparam logic [7:0]  LOGIC_DELAY_IDX     = 8'h19;
  localparam logic [7:0]  SEQ_CLK_IDX         = 8'h1a;
  localparam int          BYTE_PER_WORD       = 4;

  localparam logic [15:0] DELAY_RESET         = 16'h01fc;
  localparam logic [15:0] SEQ_CLK_RESET       = 16'h00d1;

  // ****************************************
  // Field layout
  // ****************************************
  localparam int          DELAY_STEP_LSB      = 2;
  localparam int          DELAY_STEP_W        = 7;
  localparam int          PHASE_LSB           = 0;
  localparam int          PHASE_W             = 2;
  localparam int          POST_DIV_LSB        = 5;
  localparam int          POST_DIV_W          = 3;
  localparam int          PRE_DIV_LSB         = 1;
  localparam int          PRE_DIV_W           = 4;
  localparam int          SEQ_EN_BIT          = 0;

  localparam logic [3:0]  PRE_DIV_BY2         = 4'h2;
  localparam logic [3:0]  PRE_DIV_BY4         = 4'h4;
  localparam logic [3:0]  PRE_DIV_BY8         = 4'h8;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    SDSR_PH_IN_PHASE_INTERP_CLOCK_INV = 2'h0,
    SDSR_PH_QUADRATURE_INTERP_CLOCK_INV = 2'h1,
    SDSR_PH_QUADRATURE_INTERP_CLOCK     = 2'h2,
    SDSR_PH_IN_PHASE_INTERP_CLOCK     = 2'h3
  } sdsr_phase_t;

  typedef struct packed {
    logic [DELAY_STEP_W-1:0] step;
    sdsr_phase_t             phase;
  } sdsr_delay_t;

  typedef struct packed {
    logic [POST_DIV_W-1:0] post_div;
    logic [PRE_DIV_W-1:0]  pre_div;
    logic                  enable;
  } sdsr_seqclk_t;

endpackage

// File: logic/sdsr_regs.sv
`timescale 1ns/1ps
`default_nettype none

module sdsr_regs (
  input  wire logic                core_clk,
  input  wire logic                reset,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  output sdsr_pkg::sdsr_delay_t    out3_delay,
  output sdsr_pkg::sdsr_delay_t    logic_ref_delay,
  output sdsr_pkg::sdsr_seqclk_t   seq_clk_cfg,
  output logic                     pre_divide_valid,
  output logic [7:0]               post_divide_ratio
);

  // ****************************************
  // Address decode
  // ****************************************
  function automatic logic [1:0] decode(input logic [11:0] a);
    if (a == 12'(sdsr_pkg::OUT3_DELAY_IDX * sdsr_pkg::BYTE_PER_WORD))
      decode = 2'd1;
    else if (a == 12'(sdsr_pkg::LOGIC_DELAY_IDX * sdsr_pkg::BYTE_PER_WORD))
      decode = 2'd2;
    else if (a == 12'(sdsr_pkg::SEQ_CLK_IDX * sdsr_pkg::BYTE_PER_WORD))
      decode = 2'd3;
    else
      decode = 2'd0;
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  logic [15:0] out3_word;
  logic [15:0] logic_word;
  logic [15:0] seq_word;
  logic        access;
  logic [1:0]  sel;

  assign access = psel && penable && pready;
  assign sel    = decode(paddr);

  // ****************************************
  // Register storage
  // ****************************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      out3_word  <= sdsr_pkg::DELAY_RESET;
      logic_word <= sdsr_pkg::DELAY_RESET;
      seq_word   <= sdsr_pkg::SEQ_CLK_RESET;
    end else if (access && pwrite) begin
      // Full 16 bits stored; reserved bits keep whatever software writes
      case (sel)
        2'd1: out3_word  <= merge(out3_word, pwdata, pstrb);
        2'd2: logic_word <= merge(logic_word, pwdata, pstrb);
        2'd3: seq_word   <= merge(seq_word, pwdata, pstrb);
        default: ;
      endcase
    end
  end

  // ****************************************
  // APB answer: one wait state, error on unmapped address
  // ****************************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && penable && !pready && (decode(paddr) == 2'd0);
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready && !pwrite) begin
      case (decode(paddr))
        2'd1:    prdata <= {16'h0000, out3_word};
        2'd2:    prdata <= {16'h0000, logic_word};
        2'd3:    prdata <= {16'h0000, seq_word};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Field outputs to delay and clock generators
  // ****************************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      out3_delay      <= sdsr_pkg::sdsr_delay_t'(sdsr_pkg::DELAY_RESET[8:0]);
      logic_ref_delay <= sdsr_pkg::sdsr_delay_t'(sdsr_pkg::DELAY_RESET[8:0]);
    end else begin
      out3_delay.step       <= out3_word[sdsr_pkg::DELAY_STEP_LSB +: sdsr_pkg::DELAY_STEP_W];
      out3_delay.phase      <= sdsr_pkg::sdsr_phase_t'(
                               out3_word[sdsr_pkg::PHASE_LSB +: sdsr_pkg::PHASE_W]);
      logic_ref_delay.step  <= logic_word[sdsr_pkg::DELAY_STEP_LSB +: sdsr_pkg::DELAY_STEP_W];
      logic_ref_delay.phase <= sdsr_pkg::sdsr_phase_t'(
                               logic_word[sdsr_pkg::PHASE_LSB +: sdsr_pkg::PHASE_W]);
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      seq_clk_cfg <= sdsr_pkg::sdsr_seqclk_t'(sdsr_pkg::SEQ_CLK_RESET[7:0]);
    end else begin
      seq_clk_cfg.post_div <= seq_word[sdsr_pkg::POST_DIV_LSB +: sdsr_pkg::POST_DIV_W];
      seq_clk_cfg.pre_div  <= seq_word[sdsr_pkg::PRE_DIV_LSB +: sdsr_pkg::PRE_DIV_W];
      seq_clk_cfg.enable   <= seq_word[sdsr_pkg::SEQ_EN_BIT];
    end
  end

  // Pre-divider accepts only the one-hot codes 2, 4 and 8
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pre_divide_valid <= 1'b1;
    end else begin
      case (seq_word[sdsr_pkg::PRE_DIV_LSB +: sdsr_pkg::PRE_DIV_W])
        sdsr_pkg::PRE_DIV_BY2,
        sdsr_pkg::PRE_DIV_BY4,
        sdsr_pkg::PRE_DIV_BY8: pre_divide_valid <= 1'b1;
        default:               pre_divide_valid <= 1'b0;
      endcase
    end
  end

  // Post-divider ratio is two to the field value
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      post_divide_ratio <= 8'h01 << sdsr_pkg::SEQ_CLK_RESET[7:5];
    end else begin
      post_divide_ratio <= 8'h01 << seq_word[sdsr_pkg::POST_DIV_LSB +: sdsr_pkg::POST_DIV_W];
    end
  end

endmodule

`default_nettype wire

// File: tb/sdsr_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sdsr_regs_sva (
  input wire logic                   core_clk,
  input wire logic                   reset,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [11:0]            paddr,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire sdsr_pkg::sdsr_delay_t  out3_delay,
  input wire sdsr_pkg::sdsr_delay_t  logic_ref_delay,
  input wire sdsr_pkg::sdsr_seqclk_t seq_clk_cfg,
  input wire logic                   pre_divide_valid,
  input wire logic [7:0]             post_divide_ratio
);
  // ****
  // Assertions
  // ****
  logic rd_done;
  assign rd_done = psel && penable && pready && !pwrite;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  out3_step_a: assert property (rd_done && paddr == 12'h060 |->
    prdata[8:2] == out3_delay.step) else $error("out3 step differs");
  out3_phase_a: assert property (rd_done && paddr == 12'h060 |->
    prdata[1:0] == out3_delay.phase) else $error("out3 phase differs");
  logic_step_a: assert property (rd_done && paddr == 12'h064 |->
    prdata[8:2] == logic_ref_delay.step) else $error("logic step differs");
  logic_phase_a: assert property (rd_done && paddr == 12'h064 |->
    prdata[1:0] == logic_ref_delay.phase) else $error("logic phase differs");
  post_ratio_a: assert property (
    post_divide_ratio == 8'h01 << seq_clk_cfg.post_div) else $error("post ratio wrong");
  pre_valid_a: assert property (
    pre_divide_valid == (seq_clk_cfg.pre_div inside {4'h2, 4'h4, 4'h8})) else $error("pre flag");
  seq_cfg_a: assert property (rd_done && paddr == 12'h068 |->
    prdata[7:0] == seq_clk_cfg) else $error("seq clock fields differ");
  reset_val_a: assert property ($fell(reset) |->
    out3_delay == 9'h1fc && seq_clk_cfg == 8'hd1) else $error("reset values wrong");
  field_hold_a: assert property (!psel [*3] |=> $stable(out3_delay) &&
    $stable(logic_ref_delay) && $stable(seq_clk_cfg)) else $error("fields moved");
  cover property (rd_done && paddr == 12'h068);
  cover property (pslverr);
  cover property (psel && penable && pready && pwrite);
endmodule
bind sdsr_regs sdsr_regs_sva sdsr_regs_sva_i (.core_clk, .reset, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .out3_delay, .logic_ref_delay, .seq_clk_cfg,
  .pre_divide_valid, .post_divide_ratio);
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [11:0] A3 = {2'b00, sdsr_pkg::OUT3_DELAY_IDX, 2'b00};
  localparam logic [11:0] AL = {2'b00, sdsr_pkg::LOGIC_DELAY_IDX, 2'b00};
  localparam logic [11:0] AC = {2'b00, sdsr_pkg::SEQ_CLK_IDX, 2'b00};
  logic                   core_clk, reset, psel, penable, pwrite, pready, pslverr, se;
  logic                   pre_divide_valid;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata, rd;
  logic [3:0]             pstrb;
  logic [7:0]             post_divide_ratio;
  sdsr_pkg::sdsr_delay_t  out3_delay, logic_ref_delay;
  sdsr_pkg::sdsr_seqclk_t seq_clk_cfg;
  int                     err_total = 0;
  int                     num_checks = 0;
  sdsr_regs sdsr_regs_i (.core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .out3_delay, .logic_ref_delay, .seq_clk_cfg,
    .pre_divide_valid, .post_divide_ratio);
  // ****
  // Tasks
  // ****
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(negedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    @(posedge core_clk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_reset;
    bus(1'b0, A3, 32'h0000_0000);
    chk(rd, 32'(sdsr_pkg::DELAY_RESET));
    bus(1'b0, AL, 32'h0000_0000);
    chk(rd, 32'(sdsr_pkg::DELAY_RESET));
    bus(1'b0, AC, 32'h0000_0000);
    chk(rd, 32'(sdsr_pkg::SEQ_CLK_RESET));
    chk(32'(post_divide_ratio), 32'h0000_0040);
    $display("test reset done");
  endtask
  task automatic t_delay;
    logic [31:0] d;
    for (int i = 0; i < 2; i++) begin
      for (int p = 0; p < 4; p++) begin
        d = {23'h00_0000, p[0] ? 7'h00 : 7'h7f, p[1:0]};
        bus(1'b1, i ? AL : A3, d);
        repeat (4) @(posedge core_clk);
        bus(1'b0, i ? AL : A3, 32'h0000_0000);
        chk(rd, d);
        chk(32'(i ? logic_ref_delay : out3_delay), d);
      end
    end
    $display("test delay done");
  endtask
  task automatic t_seq;
    logic [31:0] d;
    logic [3:0]  pre;
    for (int k = 0; k < 8; k++) begin
      pre = (k % 4 == 3) ? 4'h3 : 4'h2 << (k % 4);
      d = {24'h00_0000, k[2:0], pre, k[0]};
      bus(1'b1, AC, d);
      bus(1'b0, AC, 32'h0000_0000);
      chk(rd, d);
      chk(32'(seq_clk_cfg), d);
      chk(32'(post_divide_ratio), 32'h0000_0001 << k);
      chk(32'(pre_divide_valid), 32'(k % 4 != 3));
    end
    $display("test seq done");
  endtask
  task automatic t_bad;
    bus(1'b1, 12'h06c, 32'h0000_00ff);
    chk(32'(se), 32'h0000_0001);
    bus(1'b0, 12'h06c, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    $display("test unmapped done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    err_total++;
    stop_test();
  end
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hf;
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    t_delay();
    t_seq();
    t_bad();
    stop_test();
  end
endmodule
`default_nettype wire
